// ===== design/ccpc_pkg.sv
package ccpc_pkg;

    // ************************************************************
    // Register map and field layout.
    // ************************************************************
    localparam logic [7:0]  ADDR_POWER_CTRL  = 8'h20;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h40;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h44;
    localparam logic [7:0]  ADDR_CLK_STATE   = 8'h48;
    localparam logic [31:0] POWER_CTRL_RESET = 32'h0000_0000;

    localparam int BIT_ACTION_SELECT = 0;
    localparam int BIT_GATING_ENABLE = 16;
    localparam int BIT_RATE_CHANGED  = 24;
    localparam int BIT_ACCESS_SEEN   = 25;

    // Interrupt status bit positions.
    localparam int IRQ_BIT_ACCESS = 0;
    localparam int IRQ_BIT_RATE   = 1;
    localparam int IRQ_WIDTH      = 2;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int SLOW_DIVIDE   = 16;
    localparam int IDLE_TIME_NS  = 64;
    localparam int CLK_PERIOD_NS = 8;
    localparam int IDLE_CYCLES   = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Card clock drive modes.
    typedef enum logic [1:0] {
        CCPC_CLK_FULL = 2'b00,
        CCPC_CLK_STOP = 2'b01,
        CCPC_CLK_SLOW = 2'b10
    } ccpc_clk_mode_t;

    // Register bus request bundle.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ccpc_bus_req_t;

endpackage

// ===== design/ccpc_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser; the first stage feeds only the second.
module ccpc_sync (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage1;

    // Both stages reset to zero so the edge detector after it starts quiet.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // ccpc_sync

// ===== design/ccpc_clk_gen.sv
`timescale 1ns/1ps

// Builds the card clock enable from the sampled link clock edges.
module ccpc_clk_gen (
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    input  wire logic                    link_edge,
    input  wire ccpc_pkg::ccpc_clk_mode_t mode,
    output logic                         card_clk_en
);

    logic [$clog2(ccpc_pkg::SLOW_DIVIDE)-1:0] div_count;

    // Full rate passes every edge, slow passes one in sixteen, stop passes none.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_count   <= '0;
            card_clk_en <= 1'b0;
        end else begin
            card_clk_en <= 1'b0;
            if (link_edge) begin
                div_count <= div_count + 1'b1;
                case (mode)
                    ccpc_pkg::CCPC_CLK_FULL: card_clk_en <= 1'b1;
                    ccpc_pkg::CCPC_CLK_SLOW: card_clk_en <= (div_count == '0);
                    ccpc_pkg::CCPC_CLK_STOP: card_clk_en <= 1'b0;
                    default:                 card_clk_en <= 1'b1;
                endcase
            end
        end
    end

endmodule // ccpc_clk_gen

// ===== design/ccpc_top.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

// Function
// - Reserved bits 31-26, 23-17 and 15-1 always read as zero.
// - Card access sets the access-seen flag at bit 25.
// - A read of the power register clears the access-seen flag unless a card access lands in the same cycle.
// - Bit 24 reads one once the card clock rate has changed.
// - Clock action applies only while the gating enable at bit 16 is set.
// - Enabled with selector zero, idle interface stops the card clock.
// - Enabled with selector one, idle interface slows clock to one sixteenth.
// - Of the two resets, only the global cold reset clears status flags 25 and 24.
// - Power register at offset 20h resets to all zeros.
module ccpc_top (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        global_cold_reset,
    input  wire logic        link_clk,
    input  wire logic        card_access,
    input  wire logic        card_idle,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    output logic             card_clk_en,
    output logic             clk_mode_changed
);

    // ************************************************************
    // Input synchronisation.
    // ************************************************************
    logic link_clk_s;
    logic access_s;
    logic idle_s;
    logic link_clk_d;
    logic link_edge;
    logic access_d;
    logic access_pulse;

    // Link clock from the card; its phase bears no relation to sys_clk.
    ccpc_sync u_sync_clk (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (link_clk),
        .sync_out (link_clk_s)
    );

    // Card access level; every rising edge counts as one access.
    ccpc_sync u_sync_acc (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (card_access),
        .sync_out (access_s)
    );

    // Idle level from the clock-run side, high while the interface is idle.
    ccpc_sync u_sync_idle (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (card_idle),
        .sync_out (idle_s)
    );

    // Delayed copy of the sampled link clock; a rising edge is one card clock cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link_clk_d <= 1'b0;
        end else begin
            link_clk_d <= link_clk_s;
        end
    end

    // Delayed copy of the sampled access level. Both delays reset to the synchroniser's
    // reset value, so a quiet pin gives no false edge after reset.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            access_d <= 1'b0;
        end else begin
            access_d <= access_s;
        end
    end

    assign link_edge    = link_clk_s & ~link_clk_d;
    assign access_pulse = access_s & ~access_d;

    // ************************************************************
    // Register bus.
    // ************************************************************
    ccpc_pkg::ccpc_bus_req_t req;
    logic                    hit_ctrl;
    logic                    wr_ctrl;
    logic                    rd_ctrl;
    logic                    wr_status;
    logic                    wr_mask;

    // The bus is on sys_clk already, so it is used without synchronisers.
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;
    assign hit_ctrl  = (req.addr == ccpc_pkg::ADDR_POWER_CTRL);

    // One qualified strobe per register keeps the address decode in one place.
    assign wr_ctrl   = req.wr & hit_ctrl;
    assign rd_ctrl   = req.rd & hit_ctrl;
    assign wr_status = req.wr & (req.addr == ccpc_pkg::ADDR_IRQ_STATUS);
    assign wr_mask   = req.wr & (req.addr == ccpc_pkg::ADDR_IRQ_MASK);

    // Control fields of the power register, written only by software.
    logic gating_enable;
    logic action_select;

    // Control bits follow the warm reset, unlike the two status flags.
    always_ff @(posedge sys_clk) begin
        if (srst || global_cold_reset) begin
            gating_enable <= ccpc_pkg::POWER_CTRL_RESET[ccpc_pkg::BIT_GATING_ENABLE];
            action_select <= ccpc_pkg::POWER_CTRL_RESET[ccpc_pkg::BIT_ACTION_SELECT];
        end else if (wr_ctrl) begin
            gating_enable <= req.wdata[ccpc_pkg::BIT_GATING_ENABLE];
            action_select <= req.wdata[ccpc_pkg::BIT_ACTION_SELECT];
        end
    end

    // ************************************************************
    // Access-seen flag.
    // ************************************************************
    logic access_seen;

    // A card access in the same cycle as a clearing read wins, so none is lost.
    // Only the cold reset clears it; a warm reset must not hide an access.
    always_ff @(posedge sys_clk) begin
        if (global_cold_reset) begin
            access_seen <= 1'b0;
        end else if (access_pulse) begin
            access_seen <= 1'b1;
        end else if (rd_ctrl) begin
            access_seen <= 1'b0;
        end
    end

    // ************************************************************
    // Clock mode selection.
    // ************************************************************
    ccpc_pkg::ccpc_clk_mode_t mode;
    ccpc_pkg::ccpc_clk_mode_t next_mode;

    // The idle decision comes from the card-side protocol as a level.
    always_comb begin
        next_mode = ccpc_pkg::CCPC_CLK_FULL;
        if (gating_enable && idle_s) begin
            if (action_select) begin
                next_mode = ccpc_pkg::CCPC_CLK_SLOW;
            end else begin
                next_mode = ccpc_pkg::CCPC_CLK_STOP;
            end
        end
    end

    // Mode is registered so the clock generator sees at most one change per cycle.
    always_ff @(posedge sys_clk) begin
        if (srst || global_cold_reset) begin
            mode <= ccpc_pkg::CCPC_CLK_FULL;
        end else begin
            mode <= next_mode;
        end
    end

    // The card clock enable is a registered pulse per passed link edge, so the
    // output pin comes straight from a flop inside the generator.
    ccpc_clk_gen u_clk_gen (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .link_edge   (link_edge),
        .mode        (mode),
        .card_clk_en (card_clk_en)
    );

    // ************************************************************
    // Rate-changed flag.
    // ************************************************************
    logic rate_changed;
    logic rate_event;

    // Any departure from full rate counts as a change of the card clock frequency.
    // Stop is treated as a change too, since the card then sees no clock at all.
    assign rate_event = (mode != ccpc_pkg::CCPC_CLK_FULL);

    // Sticky until cold reset so software can see that gating ever happened.
    always_ff @(posedge sys_clk) begin
        if (global_cold_reset) begin
            rate_changed <= 1'b0;
        end else if (rate_event) begin
            rate_changed <= 1'b1;
        end
    end

    // The pin copies bit 24 through a flop, one cycle behind the register.
    always_ff @(posedge sys_clk) begin
        if (global_cold_reset) begin
            clk_mode_changed <= 1'b0;
        end else begin
            clk_mode_changed <= rate_changed;
        end
    end

    // ************************************************************
    // Interrupts.
    // ************************************************************
    logic [ccpc_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [ccpc_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [ccpc_pkg::IRQ_WIDTH-1:0] irq_set;
    logic                           rate_event_d;

    // Remembers last cycle's gating state so only entry into gating raises an event.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rate_event_d <= 1'b0;
        end else begin
            rate_event_d <= rate_event;
        end
    end

    // Event sources, one per status bit.
    assign irq_set[ccpc_pkg::IRQ_BIT_ACCESS] = access_pulse;
    assign irq_set[ccpc_pkg::IRQ_BIT_RATE]   = rate_event & ~rate_event_d;

    // Each status bit is sticky on its own; a set beats a write-one-to-clear in one cycle,
    // so an event that lands on the clearing write is never lost.
    for (genvar b = 0; b < ccpc_pkg::IRQ_WIDTH; b++) begin : g_irq_bit
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                irq_status[b] <= 1'b0;
            end else if (irq_set[b]) begin
                irq_status[b] <= 1'b1;
            end else if (wr_status && req.wdata[b]) begin
                irq_status[b] <= 1'b0;
            end
        end
    end

    // Mask bits share the status layout; a one lets that status bit reach the pin.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= req.wdata[ccpc_pkg::IRQ_WIDTH-1:0];
        end
    end

    // The pin is registered, so it follows status and mask one cycle late.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ************************************************************
    // Power register image.
    // ************************************************************
    logic [31:0] ctrl_image;

    // Reserved positions are tied low here, so no later change can leak into them.
    always_comb begin
        ctrl_image                              = 32'h0000_0000;
        ctrl_image[ccpc_pkg::BIT_ACCESS_SEEN]   = access_seen;
        ctrl_image[ccpc_pkg::BIT_RATE_CHANGED]  = rate_changed;
        ctrl_image[ccpc_pkg::BIT_GATING_ENABLE] = gating_enable;
        ctrl_image[ccpc_pkg::BIT_ACTION_SELECT] = action_select;
    end

    // ************************************************************
    // Read data.
    // ************************************************************
    logic [31:0] next_rdata;

    // Unmapped addresses read zero; every reserved bit is held at zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (req.addr)
            ccpc_pkg::ADDR_POWER_CTRL: next_rdata = ctrl_image;
            ccpc_pkg::ADDR_IRQ_STATUS: next_rdata[ccpc_pkg::IRQ_WIDTH-1:0] = irq_status;
            ccpc_pkg::ADDR_IRQ_MASK:   next_rdata[ccpc_pkg::IRQ_WIDTH-1:0] = irq_mask;
            ccpc_pkg::ADDR_CLK_STATE:  next_rdata[1:0] = mode;
            default:                   next_rdata = 32'h0000_0000;
        endcase
    end

    // Data stand only in the cycle after the read strobe.
    // Idle zeros keep a stale value from passing for a fresh read.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // ccpc_top

// ===== dv/ccpc_top_assertions.sv
`timescale 1ns/1ps

// Port-level checks of the card clock power register.
module ccpc_top_assertions (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        global_cold_reset,
    input wire logic        card_access,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq,
    input wire logic        card_clk_en,
    input wire logic        clk_mode_changed
);
    logic       rd_pow;
    logic       en_q;
    logic [4:0] off_cnt;
    logic [4:0] acc_age;
    logic [3:0] gap;

    assign rd_pow = reg_rd && (reg_addr == ccpc_pkg::ADDR_POWER_CTRL);

    // Shadow of the gating enable, since the checker cannot see inside.
    always_ff @(posedge sys_clk) begin
        if (srst || global_cold_reset) en_q <= 1'b0;
        else if (reg_wr && reg_addr == ccpc_pkg::ADDR_POWER_CTRL) en_q <= reg_wdata[16];
    end

    // Cycles with gating off; it saturates so long runs never wrap.
    always_ff @(posedge sys_clk) begin
        if (srst || global_cold_reset || en_q) off_cnt <= 5'd0;
        else if (off_cnt != 5'd31) off_cnt <= off_cnt + 5'd1;
    end

    // Age of a card access that no read has reported yet.
    always_ff @(posedge sys_clk) begin
        if (global_cold_reset) acc_age <= 5'd0;
        else if ($rose(card_access)) acc_age <= 5'd1;
        else if (rd_pow) acc_age <= 5'd0;
        else if (acc_age != 5'd0 && acc_age != 5'd31) acc_age <= acc_age + 5'd1;
    end

    // Cycles since the last card clock pulse.
    always_ff @(posedge sys_clk) begin
        if (srst || card_clk_en) gap <= 4'd0;
        else if (gap != 4'd15) gap <= gap + 4'd1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (global_cold_reset);

    AST_RSVD_ZERO:
        assert property ($past(rd_pow) |-> (reg_rdata & 32'hfcfefffe) == 32'h0)
        else $error("reserved bits read nonzero");
    AST_ACCESS_SET:
        assert property (rd_pow && acc_age >= 5'd8 |=> reg_rdata[25])
        else $error("access flag missing");
    AST_READ_CLEARS:
        assert property ((!card_access)[*8] ##0 rd_pow ##1 !card_access ##1
            (rd_pow && !card_access) |=> !reg_rdata[25])
        else $error("access flag not cleared by read");
    AST_MODE_PIN:
        assert property ($past(rd_pow) && !srst && !$past(srst) |->
            reg_rdata[24] == clk_mode_changed)
        else $error("mode bit and pin disagree");
    AST_NO_CHANGE_OFF:
        assert property (off_cnt == 5'd31 |-> !$rose(clk_mode_changed))
        else $error("rate changed while gating off");
    AST_STICKY:
        assert property ($fell(clk_mode_changed) |-> $past(global_cold_reset))
        else $error("mode flag dropped without reset");
    AST_RESET_ZERO:
        assert property (srst |=> reg_rdata == 32'h0 && !irq && !card_clk_en)
        else $error("outputs not cleared by reset");
    AST_FULL_RATE:
        assert property (off_cnt == 5'd31 |-> gap < 4'd12)
        else $error("card clock slowed while gating off");
endmodule // ccpc_top_assertions

// ===== dv/ccpc_card_model.sv
`timescale 1ns/1ps

// Card side: free-running link clock, access pulses and the idle level.
module ccpc_card_model (
    input  wire logic idle_req,
    output logic      link_clk,
    output logic      card_access,
    output logic      card_idle
);
    // The clock runs freely, offset so its phase is unrelated to sys_clk.
    initial begin
        link_clk = 1'b0;
        #3;
        forever #40 link_clk = ~link_clk;
    end

    assign card_idle = idle_req;

    // One access, held long enough that the sampler cannot miss it.
    // It starts off the sys_clk edge so the sampling flop never races it.
    initial card_access = 1'b0;
    task automatic access();
        #2 card_access = 1'b1;
        #48 card_access = 1'b0;
        #48;
    endtask
endmodule // ccpc_card_model

// ===== dv/ccpc_top_tb.sv
`timescale 1ns/1ps

module ccpc_top_tb;
    logic        sys_clk, srst, global_cold_reset, idle_req, reg_wr, reg_rd;
    logic        link_clk, card_access, card_idle, irq, card_clk_en, clk_mode_changed;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, q, seed;
    int          n_mismatch, checks_done, cnt;

    ccpc_top u_ccpc_top (.sys_clk(sys_clk), .srst(srst), .global_cold_reset(global_cold_reset),
        .link_clk(link_clk), .card_access(card_access), .card_idle(card_idle),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .card_clk_en(card_clk_en),
        .clk_mode_changed(clk_mode_changed));
    ccpc_card_model u_ccpc_card_model (.idle_req(idle_req), .link_clk(link_clk),
        .card_access(card_access), .card_idle(card_idle));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected register image from the control word and both flags.
    function automatic logic [31:0] pow(input logic [31:0] w, input logic a, input logic m);
        return {6'h00, a, m, 7'h00, w[16], 15'h0000, w[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // The read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Pulses are looked at 1 ns after their launching edge, where they have settled.
    task automatic count(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (card_clk_en === 1'b1) cnt++;
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // A hang is cut short well beyond the few thousand cycles needed.
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        seed = 32'h7659;
        srst = 1'b1;
        global_cold_reset = 1'b1;
        idle_req = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        global_cold_reset <= 1'b0;
        rd(8'h20, q);
        chk(q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(8'h20, seed);
            rd(8'h20, q);
            chk(q, pow(seed, 1'b0, 1'b0));
        end
        wr(8'h24, seed);
        rd(8'h24, q);
        chk(q, 32'h0);
        // Access with the interrupt unmasked, then masked.
        wr(8'h20, 32'h0);
        wr(8'h44, 32'h1);
        u_ccpc_card_model.access();
        repeat (8) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        rd(8'h20, q);
        chk(q, pow(32'h0, 1'b1, 1'b0));
        rd(8'h20, q);
        chk(q, 32'h0);
        wr(8'h40, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h44, 32'h0);
        u_ccpc_card_model.access();
        repeat (8) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h40, q);
        chk(q, 32'h1);
        wr(8'h40, 32'h3);
        // Selector set but gating off: the card clock must keep full rate.
        wr(8'h20, 32'h1);
        idle_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        count(400);
        // 400 cycles of 8 ns hold exactly 40 link periods of 80 ns.
        chk(cnt, 32'd40);
        rd(8'h48, q);
        chk(q, 32'h0);
        wr(8'h20, 32'h10001);
        repeat (40) @(posedge sys_clk);
        rd(8'h48, q);
        chk(q, 32'h2);
        count(1600);
        // 160 link edges, one passed in every sixteen.
        chk(cnt, 32'd10);
        rd(8'h20, q);
        chk(q, pow(32'h10001, 1'b1, 1'b1));
        chk({31'h0, clk_mode_changed}, 32'h1);
        rd(8'h40, q);
        chk(q, 32'h2);
        wr(8'h20, 32'h10000);
        repeat (40) @(posedge sys_clk);
        rd(8'h48, q);
        chk(q, 32'h1);
        count(400);
        chk(cnt, 0);
        wr(8'h20, 32'h0);
        repeat (40) @(posedge sys_clk);
        rd(8'h48, q);
        chk(q, 32'h0);
        // A warm reset keeps the mode flag; only the cold one clears it.
        // Control bits and a fresh access ahead of it show what each reset clears.
        idle_req <= 1'b0;
        u_ccpc_card_model.access();
        wr(8'h20, 32'h10001);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        rd(8'h20, q);
        chk(q, pow(32'h0, 1'b1, 1'b1));
        chk({31'h0, clk_mode_changed}, 32'h1);
        global_cold_reset <= 1'b1;
        @(posedge sys_clk);
        global_cold_reset <= 1'b0;
        rd(8'h20, q);
        chk(q, 32'h0);
        chk({31'h0, clk_mode_changed}, 32'h0);
        end_of_test();
    end
endmodule // ccpc_top_tb

bind ccpc_top ccpc_top_assertions u_ccpc_top_assertions (.sys_clk(sys_clk), .srst(srst),
    .global_cold_reset(global_cold_reset), .card_access(card_access), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .card_clk_en(card_clk_en), .clk_mode_changed(clk_mode_changed));
